// >>> hw/fbp_pkg.sv
/*
  Shared constants and types of the flash block protection gate:
  array geometry, protection states, request kinds and reset values.
  Assumes a word-addressed 32-bit flash array behind the gate.
*/
package fbp_pkg;
  localparam int unsigned FBP_STORE_BYTES  = 98304;  // 96 KB
  localparam int unsigned FBP_ERASE_BYTES  = 1024;
  localparam int unsigned FBP_PROT_BYTES   = 2048;
  localparam int unsigned FBP_WORD_BYTES   = 4;
  localparam int unsigned FBP_WORDS        = FBP_STORE_BYTES / FBP_WORD_BYTES;
  localparam int unsigned FBP_BLK_WORDS    = FBP_ERASE_BYTES / FBP_WORD_BYTES;
  localparam int unsigned FBP_NUM_BLK      = FBP_STORE_BYTES / FBP_ERASE_BYTES;
  localparam int unsigned FBP_NUM_PROT     = FBP_STORE_BYTES / FBP_PROT_BYTES;
  localparam int unsigned FBP_AW           = 15;  // word address width
  localparam int unsigned FBP_BW           = 7;   // erase block index width
  localparam int unsigned FBP_PW           = 6;   // protection unit index width
  localparam int unsigned FBP_OFSW         = 8;   // word within erase block
  localparam int unsigned FBP_BLK_LSB      = 8;
  localparam int unsigned FBP_PROT_LSB     = 9;
  localparam logic [31:0] FBP_ERASED_WORD  = 32'hffff_ffff;
  localparam logic [31:0] FBP_RD_ZERO      = 32'h0000_0000;
  localparam logic [FBP_OFSW-1:0] FBP_OFS_LAST = 8'hff;
  localparam logic [FBP_AW-1:0] FBP_WORD_LAST = 15'h5fff;

  typedef enum logic [1:0] {
    FBP_PROT_OPEN  = 2'h0,
    FBP_PROT_RO    = 2'h1,
    FBP_PROT_XO    = 2'h2
  } fbp_prot_t;

  typedef enum logic [2:0] {
    FBP_OP_NONE    = 3'h0,
    FBP_OP_FETCH   = 3'h1,
    FBP_OP_READ    = 3'h2,
    FBP_OP_DBG     = 3'h3,
    FBP_OP_PROG    = 3'h4,
    FBP_OP_ERASE   = 3'h5,
    FBP_OP_SETPROT = 3'h6
  } fbp_op_t;
endpackage

// >>> hw/fbp_array.sv
/*
  Flash array model storage: 24576 words of 32 bits with one read or
  write port per cycle. Assumes the gate has already checked protection.
  Program only clears bits, as real flash cells do.
*/
`timescale 1ns/1ps
module fbp_array
  import fbp_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 we_i,
  input  wire logic [fbp_pkg::FBP_AW-1:0] addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 erase_i,
  output logic      [31:0]          rdata_o
);
  logic [31:0] mem [0:FBP_WORDS-1];

  // No reset on the array: flash contents survive reset
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= erase_i ? FBP_ERASED_WORD : (mem[addr_i] & wdata_i);
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// >>> hw/fbp_gate.sv
/*
  Flash block protection gate: checks each fetch, data read, debug read,
  program and erase against the 2 KB unit's protection state and drives
  the flash array. One request at a time; req_i is taken when ready_o is
  high. Refusals end with done_o and refused_o together and zero data.
  Assumes requesters are synchronous to clk_i, so no input synchroniser.
*/
// Notes on behaviour
// - 96 KB store behind the gate
// - Erase acts on one 1 KB block
// - Erased block reads back all ones
// - Two blocks form one protected 2 KB unit
// - Units are open, read-only or execute-only
// - Read-only refuses erase and program
// - Execute-only refuses erase and program
// - Execute-only serves instruction fetches and set-protection only
`timescale 1ns/1ps
module fbp_gate
  import fbp_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       req_i,
  input  wire logic [2:0]                 op_i,
  input  wire logic [fbp_pkg::FBP_AW-1:0] addr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic                       viol_clr_i,
  output logic                            ready_o,
  output logic                            done_o,
  output logic                            refused_o,
  output logic      [31:0]                rdata_o,
  output logic                            viol_o
);
  typedef enum logic [1:0] {FBP_ST_IDLE, FBP_ST_READ, FBP_ST_ERASE} fbp_state_t;

  logic       rst_s1_q, rst_n_q;
  fbp_state_t st_q, st_d;
  fbp_op_t    op_q, op_d;
  logic [FBP_AW-1:0]   addr_q, addr_d;
  logic [1:0]          prot_q [FBP_NUM_PROT];
  logic [1:0]          prot_d [FBP_NUM_PROT];
  logic        ready_q, ready_d, done_q, done_d, ref_q, ref_d, viol_q, viol_d;
  logic [31:0] rdata_q, rdata_d;
  logic        mem_we, mem_erase;
  logic [FBP_AW-1:0] mem_addr;
  logic [31:0] mem_rdata;
  logic        refuse;
  logic        bad_req;
  logic        prot_hit;
  logic [1:0]  prot_sel;
  fbp_op_t     op_in;

  function automatic logic [FBP_PW-1:0] prot_idx(input logic [FBP_AW-1:0] a);
    return a[FBP_AW-1:FBP_PROT_LSB];
  endfunction

  // Decides whether an op is barred by the unit's protection state
  function automatic logic barred(input fbp_op_t op, input logic [1:0] p);
    logic r;
    r = 1'b0;
    case (p)
      FBP_PROT_RO: r = (op == FBP_OP_PROG) || (op == FBP_OP_ERASE);
      FBP_PROT_XO: r = (op != FBP_OP_FETCH);
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  // Only the six defined request kinds are served
  function automatic logic op_known(input logic [2:0] op);
    logic k;
    k = 1'b0;
    case (op)
      FBP_OP_FETCH, FBP_OP_READ, FBP_OP_DBG, FBP_OP_PROG, FBP_OP_ERASE, FBP_OP_SETPROT: k = 1'b1;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  // Reset asserts at once but lets go on clk_i, two flops deep
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Single-port array: the gate never reads and writes in one cycle
  fbp_array u_array (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (wdata_i),
    .erase_i (mem_erase),
    .rdata_o (mem_rdata)
  );

  assign op_in  = fbp_op_t'(op_i);
  // Unknown ops and words past the store end are refused without the flag
  assign bad_req  = (addr_i > FBP_WORD_LAST) || !op_known(op_i);
  // Out-of-range words would index past the table; they never reach it
  assign prot_sel = bad_req ? FBP_PROT_OPEN : prot_q[prot_idx(addr_i)];
  // Set-protection is never barred, so any requester can reopen a unit
  assign prot_hit = !bad_req && (op_in != FBP_OP_SETPROT) && barred(op_in, prot_sel);
  assign refuse   = bad_req || prot_hit;

  always_comb begin
    st_d      = st_q;
    op_d      = op_q;
    addr_d    = addr_q;
    prot_d    = prot_q;
    ready_d   = ready_q;
    done_d    = 1'b0;
    ref_d     = 1'b0;
    rdata_d   = rdata_q;
    viol_d    = viol_q & ~viol_clr_i;
    mem_we    = 1'b0;
    mem_erase = 1'b0;
    mem_addr  = addr_i;
    case (st_q)
      FBP_ST_IDLE: begin
        // Ready rises one cycle after the internal reset lets go
        if (!ready_q) begin
          ready_d = 1'b1;
        end
        if (req_i && ready_q) begin
          op_d   = op_in;
          addr_d = addr_i;
          if (refuse) begin
            done_d  = 1'b1;
            ref_d   = 1'b1;
            rdata_d = FBP_RD_ZERO;
            if (prot_hit) begin
              viol_d = 1'b1;  // set beats clear
            end
          end else begin
            case (op_in)
              // Code 3 folds onto execute-only, the tighter of the two
              FBP_OP_SETPROT: begin
                prot_d[prot_idx(addr_i)] = wdata_i[1:0] == 2'h3 ? FBP_PROT_XO : wdata_i[1:0];
                done_d = 1'b1;
              end
              FBP_OP_PROG: begin
                mem_we = 1'b1;
                done_d = 1'b1;
              end
              FBP_OP_ERASE: begin
                addr_d  = {addr_i[FBP_AW-1:FBP_BLK_LSB], {FBP_OFSW{1'b0}}};
                ready_d = 1'b0;
                st_d    = FBP_ST_ERASE;
              end
              default: begin
                ready_d = 1'b0;
                st_d    = FBP_ST_READ;
              end
            endcase
          end
        end
      end
      // Array read is registered: data is one cycle behind the take
      FBP_ST_READ: begin
        rdata_d = mem_rdata;
        done_d  = 1'b1;
        ready_d = 1'b1;
        st_d    = FBP_ST_IDLE;
      end
      FBP_ST_ERASE: begin
        // One word per cycle: 256 cycles, only this block is touched
        // ready_o stays low, so no read can see a half-wiped block
        mem_addr  = addr_q;
        mem_we    = 1'b1;
        mem_erase = 1'b1;
        addr_d    = addr_q + 15'h0001;
        if (addr_q[FBP_OFSW-1:0] == FBP_OFS_LAST) begin
          done_d  = 1'b1;
          ready_d = 1'b1;
          st_d    = FBP_ST_IDLE;
        end
      end
      default: begin
        st_d    = FBP_ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q    <= FBP_ST_IDLE;
      op_q    <= FBP_OP_NONE;
      addr_q  <= '0;
      ready_q <= 1'b0;
      done_q  <= 1'b0;
      ref_q   <= 1'b0;
      viol_q  <= 1'b0;
      rdata_q <= FBP_RD_ZERO;
      for (int i = 0; i < FBP_NUM_PROT; i++) begin
        prot_q[i] <= FBP_PROT_OPEN;
      end
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      ready_q <= ready_d;
      done_q  <= done_d;
      ref_q   <= ref_d;
      viol_q  <= viol_d;
      rdata_q <= rdata_d;
      prot_q  <= prot_d;
    end
  end

  assign ready_o   = ready_q;
  assign done_o    = done_q;
  assign refused_o = ref_q;
  assign rdata_o   = rdata_q;
  assign viol_o    = viol_q;
endmodule

// >>> test/fbp_gate_properties.sv
/* Port checker for the protection gate, with a shadow of unit states.
   Assumes the hand-over timing of requests and answers. */
`timescale 1ns/1ps
module fbp_gate_check
  import fbp_pkg::*;
(
  input logic        clk_i,
  input logic        arst_n_i,
  input logic        req_i,
  input logic [2:0]  op_i,
  input logic [14:0] addr_i,
  input logic [31:0] wdata_i,
  input logic        viol_clr_i,
  input logic        ready_o,
  input logic        done_o,
  input logic        refused_o,
  input logic [31:0] rdata_o,
  input logic        viol_o
);
  logic [1:0] prot_q [64];
  logic       g;
  logic       wr;
  logic       rd;
  logic [1:0] pr;
  logic       ers;
  assign g = req_i && ready_o && addr_i <= FBP_WORD_LAST;
  assign wr = op_i == FBP_OP_PROG || op_i == FBP_OP_ERASE;
  assign rd = op_i == FBP_OP_READ || op_i == FBP_OP_DBG;
  assign pr = prot_q[addr_i[14:9]];
  assign ers = g && pr == 0 && op_i == FBP_OP_ERASE;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prot_q <= '{default: 2'h0};
    end else if (g && op_i == FBP_OP_SETPROT) begin
      prot_q[addr_i[14:9]] <= wdata_i[1:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wr_guard_a: assert property (g && pr != 0 && wr |=> done_o && refused_o) else $error("write not refused");
  open_prog_a: assert property (g && pr == 0 && op_i == FBP_OP_PROG |=> done_o && !refused_o) else $error("prog");
  xo_read_a: assert property (g && pr[1] && rd |=> done_o && refused_o) else $error("read not refused");
  fetch_ok_a: assert property (g && op_i == FBP_OP_FETCH |-> ##2 done_o && !refused_o) else $error("fetch");
  erase_span_a: assert property (ers |=> !ready_o [*8] ##249 done_o && !refused_o)
    else $error("erase span");
  refuse_zero_a: assert property (done_o && refused_o |-> rdata_o == FBP_RD_ZERO) else $error("data leak");
  viol_set_a: assert property (g && pr != 0 && wr |-> ##[1:2] viol_o) else $error("no violation");
  viol_hold_a: assert property (viol_o && !viol_clr_i |=> viol_o) else $error("violation lost");
  bad_op_a: assert property (g && (op_i == 3'h0 || op_i == 3'h7) && !viol_o |=> done_o && refused_o && !viol_o)
    else $error("unknown op flagged");
  range_flag_a: assert property (req_i && ready_o && addr_i > FBP_WORD_LAST && !viol_o |=> refused_o && !viol_o)
    else $error("out of range flagged");
  cover property (g && op_i == FBP_OP_ERASE);
  cover property (done_o && refused_o);
  cover property (viol_o && viol_clr_i);
endmodule
bind fbp_gate fbp_gate_check i_chk (.*);

// >>> test/fbp_host.sv
/* Requester model for the core buses and debugger.
   Assumes the gate's ready and done handshake on clk_i. */
`timescale 1ns/1ps
module fbp_host (
  input  logic        clk_i,
  input  logic        ready_i,
  input  logic        done_i,
  input  logic        refused_i,
  input  logic [31:0] rdata_i,
  output logic        req_o,
  output logic [2:0]  op_o,
  output logic [14:0] addr_o,
  output logic [31:0] wdata_o
);
  initial {req_o, op_o, addr_o, wdata_o} = '0;
  // Released address and data lines are inverted so stale values cannot pass
  task automatic xfer(input logic [2:0] o, input logic [14:0] a, input logic [31:0] w,
                      output logic [31:0] d, output logic rf);
    req_o <= 1'b1;
    op_o <= o;
    addr_o <= a;
    wdata_o <= w;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    req_o <= 1'b0;
    op_o <= 3'h0;
    addr_o <= ~a;
    wdata_o <= ~w;
    // A missing answer hangs here and is caught by the bench watchdog
    do @(posedge clk_i); while (done_i !== 1'b1);
    d = rdata_i;
    rf = refused_i;
  endtask
endmodule

// >>> test/flash_block_protection_bench.sv
/* Bench of the protection gate: erase, program and protection states.
   Assumes fbp_host drives the request side. */
`timescale 1ns/1ps
module flash_block_protection_bench;
  import fbp_pkg::*;
  logic        clk_i = 0, arst_n_i = 0, viol_clr_i = 0;
  logic        req, ready, done, refused, viol, rf;
  logic [2:0]  op;
  logic [14:0] addr;
  logic [31:0] wdata, rdata, d;
  int          mismatches = 0, num_checks = 0;
  fbp_gate i_dut (.clk_i, .arst_n_i, .req_i(req), .op_i(op), .addr_i(addr), .wdata_i(wdata), .viol_clr_i,
    .ready_o(ready), .done_o(done), .refused_o(refused), .rdata_o(rdata), .viol_o(viol));
  fbp_host i_host (.clk_i, .ready_i(ready), .done_i(done), .refused_i(refused), .rdata_i(rdata),
    .req_o(req), .op_o(op), .addr_o(addr), .wdata_o(wdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // k selects what is judged: 1 read data, 2 refusal
  task automatic rq(input logic [2:0] o, input logic [14:0] a, input logic [31:0] w, input int k = 0,
                    input logic [31:0] e = 0);
    i_host.xfer(o, a, w, d, rf);
    if (k == 1) check(d, e);
    if (k == 2) check(rf, e);
  endtask
  task automatic t_erase;
    rq(FBP_OP_ERASE, 15'h100, 0);
    rq(FBP_OP_PROG, 15'h100, 0);
    rq(FBP_OP_ERASE, 15'h0, 0);
    rq(FBP_OP_READ, 15'h00ff, 0, 1, FBP_ERASED_WORD);
    rq(FBP_OP_READ, 15'h100, 0, 1, 0);
    rq(FBP_OP_ERASE, 15'h5f00, 0);
    rq(FBP_OP_FETCH, FBP_WORD_LAST, 0, 1, FBP_ERASED_WORD);
    $display("erase test done");
  endtask
  task automatic t_prot;
    rq(FBP_OP_PROG, 15'h0, 32'h5a5a_0f0f);
    for (int i = 1; i < 4; i++) begin
      rq(FBP_OP_SETPROT, 15'h0, i);
      rq(FBP_OP_PROG, 15'h1ff, 0, 2, 1);
      rq(FBP_OP_ERASE, 15'h0, 0, 2, 1);
      check(viol, 1);
      rq(FBP_OP_FETCH, 15'h0, 0, 1, 32'h5a5a_0f0f);
      rq(FBP_OP_READ, 15'h0, 0, 1, i == 1 ? 32'h5a5a_0f0f : 0);
      rq(FBP_OP_DBG, 15'h0, 0, 2, i != 1);
      rq(FBP_OP_PROG, 15'h200, 0, 2, 0);
      viol_clr_i <= 1'b1;
      @(posedge clk_i);
      viol_clr_i <= 1'b0;
      @(posedge clk_i);
      check(viol, 0);
    end
    rq(FBP_OP_SETPROT, 15'h0, 0);
    rq(FBP_OP_PROG, 15'h0, 0, 2, 0);
    $display("protection test done");
  endtask
  task automatic t_misc;
    rq(3'h7, 15'h0, 0, 2, 1);
    rq(FBP_OP_NONE, 15'h0, 0, 2, 1);
    rq(FBP_OP_READ, 15'h6000, 0, 2, 1);
    check(viol, 0);
    rq(FBP_OP_SETPROT, 15'h0, 1);
    viol_clr_i <= 1'b1;
    rq(FBP_OP_PROG, 15'h0, 0, 2, 1);
    check(viol, 1);
    viol_clr_i <= 1'b0;
    rq(FBP_OP_SETPROT, 15'h0, 0);
    $display("misc test done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #12.5 clk_i = ~clk_i;
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wait (ready === 1'b1);
    @(posedge clk_i);
    t_erase;
    t_prot;
    t_misc;
    end_sim;
  end
  initial begin
    #100us;
    mismatches++;
    end_sim;
  end
endmodule
